// ==== rtl/nvbap_defines.vh ====
// Constants for the byte nonvolatile access port
// Summary of operation
// - 512-byte store, one byte per access
// - 9-bit linear address, hi bit8, lo 7..0
// - Address bits 15..9 read as zero
// - Write stores data byte at current address
// - Read loads data register from addressed byte
// - Read stalls processor four cycles
// - Write stalls processor two cycles
// - Self-timed write with busy indication
// - Writes need arm-then-strobe sequence
// - Registers reached in processor I/O space
// - Arm bit self-clears after four cycles
// - Write strobe clears when write completes
// - Read completes within the strobe instruction
// - During write ignore reads, freeze address
`ifndef NVBAP_DEFINES_VH
`define NVBAP_DEFINES_VH
// I/O register indices within the port
`define NVBAP_IDX_CTRL    2'h0
`define NVBAP_IDX_DATA    2'h1
`define NVBAP_IDX_ADDR_LO 2'h2
`define NVBAP_IDX_ADDR_HI 2'h3
// Control register fields
`define NVBAP_BIT_READ    0
`define NVBAP_BIT_WRITE   1
`define NVBAP_BIT_ARM     2
// Reset values
`define NVBAP_DATA_RST    8'h00
`define NVBAP_CTRL_RST    3'h0
// Timing counts in CPU cycles
`define NVBAP_ARM_CYCLES  3'h4
`define NVBAP_READ_STALL  3'h4
`define NVBAP_WRITE_STALL 3'h2
// Write time in oscillator ticks
`define NVBAP_WRITE_TICKS 17'h10800
`endif

// ==== rtl/nvbap_port.v ====
// Byte nonvolatile access port on the processor I/O register bus
`timescale 1ns/1ps
`include "nvbap_defines.vh"
// Programming model, one byte per access
//  - Address pair holds a 9-bit byte index, upper bits read zero
//  - Data register holds the byte to store, or the byte last fetched
//  - Control holds read strobe, write strobe and arm bit
// Write sequence
//  - Poll write strobe low, then load address and data
//  - Set the arm bit, then the write strobe within four cycles
//  - Core halts two cycles, then the store times itself
// Read sequence
//  - Load address, then set the read strobe
//  - Data register holds the byte before the next instruction
//  - Core halts four cycles
// Hazards and limits
//  - A write in flight freezes the address and drops read strobes
//  - Write time runs on oscillator ticks, not on the CPU clock
//  - The byte lands only at the end of the full write time
//  - Address comes out of reset as zero; software must not rely on it
//  - Store contents are not reset, only the registers are
module nvbap_port #(
    parameter WRITE_TICKS = `NVBAP_WRITE_TICKS
) (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_nrst,
    // Processor I/O register bus
    input  wire [1:0] i_io_addr,
    input  wire       i_io_wr,
    input  wire       i_io_rd,
    input  wire [7:0] i_io_wdata,
    output reg  [7:0] o_io_rdata,
    output wire       o_cpu_stall,
    // Write timing oscillator, asynchronous
    input  wire       i_osc_clk
);
    // Byte store, flip-flops indexed by address
    reg [7:0]  mem [0:511];

    // Programmer-visible registers
    reg [8:0]  nv_byte_addr;
    reg [7:0]  nv_byte_data;
    reg        master_write_arm;
    reg        write_strobe;

    // Write engine state, latched at the strobe
    reg [16:0] write_ticks_left;
    reg [8:0]  write_addr;
    reg [7:0]  write_byte;

    // Oscillator synchroniser and edge detector
    reg        osc_meta;
    reg        osc_sync;
    reg        osc_prev;

    // Timer loads
    reg        arm_load;
    reg        read_stall_load;
    reg        write_stall_load;

    // Bus decode and request qualifiers
    wire       wr_ctrl;
    wire       wr_data;
    wire       wr_lo;
    wire       wr_hi;
    wire       addr_open;
    wire       arm_live;
    wire       read_stall;
    wire       write_stall;
    wire       osc_tick;
    wire       write_done;
    wire       start_rd;
    wire       start_wr;

    // Register decode of a bus write
    assign wr_ctrl = i_io_wr && (i_io_addr == `NVBAP_IDX_CTRL);
    assign wr_data = i_io_wr && (i_io_addr == `NVBAP_IDX_DATA);
    assign wr_lo   = i_io_wr && (i_io_addr == `NVBAP_IDX_ADDR_LO);
    assign wr_hi   = i_io_wr && (i_io_addr == `NVBAP_IDX_ADDR_HI);

    // Address may move only while no write is in flight
    assign addr_open = !write_strobe;

    // Rising oscillator edge, seen once per tick
    assign osc_tick = osc_sync && !osc_prev;

    // Last tick of the write time commits the byte
    assign write_done = write_strobe && osc_tick && (write_ticks_left == 17'h00001);

    // Read strobe dropped while a write is in flight
    assign start_rd = wr_ctrl && i_io_wdata[`NVBAP_BIT_READ] && !write_strobe;

    // Write strobe needs a live arm and an idle engine
    assign start_wr = wr_ctrl && i_io_wdata[`NVBAP_BIT_WRITE] && master_write_arm
                      && !write_strobe;

    // Arm window timer; the flag lags it by a cycle, so load one less
    // to keep the arm bit set for exactly four cycles
    nvbap_stall_timer #(.WIDTH(3)) u_arm (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_load  (arm_load),
        .i_count (`NVBAP_ARM_CYCLES - 3'h1),
        .o_busy  (arm_live)
    );

    // Read stall timer
    nvbap_stall_timer #(.WIDTH(3)) u_rd_stall (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_load  (read_stall_load),
        .i_count (`NVBAP_READ_STALL),
        .o_busy  (read_stall)
    );

    // Write stall timer
    nvbap_stall_timer #(.WIDTH(3)) u_wr_stall (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_load  (write_stall_load),
        .i_count (`NVBAP_WRITE_STALL),
        .o_busy  (write_stall)
    );

    // Timer loads, combinational from bus strobes
    always @* begin
        arm_load         = wr_ctrl && i_io_wdata[`NVBAP_BIT_ARM];
        read_stall_load  = start_rd;
        write_stall_load = start_wr;
    end

    // Stall holds the core for the timer windows
    assign o_cpu_stall = read_stall || write_stall;

    // Oscillator edge detect after two-flop synchroniser
    // Only osc_sync reads the first flop, so metastability stays there
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            osc_meta <= 1'h0;
            osc_sync <= 1'h0;
            osc_prev <= 1'h0;
        end else begin
            osc_meta <= i_osc_clk;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // Arm flag mirrors its timer; dropped by hardware after four cycles
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            master_write_arm <= 1'h0;
        end else if (arm_load) begin
            master_write_arm <= 1'h1; // A new arm write wins over expiry
        end else begin
            master_write_arm <= arm_live;
        end
    end

    // Address registers, frozen while a write runs
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            nv_byte_addr <= 9'h000; // Software must still load it first
        end else if (addr_open) begin
            if (wr_lo) begin
                nv_byte_addr[7:0] <= i_io_wdata;
            end
            if (wr_hi) begin
                nv_byte_addr[8] <= i_io_wdata[0];
            end
        end
    end

    // Data register: written by bus, loaded by a read
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            nv_byte_data <= `NVBAP_DATA_RST;
        end else if (start_rd) begin
            nv_byte_data <= mem[nv_byte_addr]; // Ready next cycle
        end else if (wr_data) begin
            nv_byte_data <= i_io_wdata;
        end
    end

    // Self-timed write, counted on oscillator ticks
    // Address and byte are latched so later bus writes cannot corrupt them
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            write_strobe     <= 1'h0;
            write_ticks_left <= 17'h00000;
            write_addr       <= 9'h000;
            write_byte       <= 8'h00;
        end else if (start_wr) begin
            write_strobe     <= 1'h1;
            write_ticks_left <= WRITE_TICKS[16:0];
            write_addr       <= nv_byte_addr;
            write_byte       <= nv_byte_data;
        end else if (write_strobe && osc_tick) begin
            if (write_done) begin
                write_strobe <= 1'h0;
            end
            write_ticks_left <= write_ticks_left - 17'h00001;
        end
    end

    // Byte committed at the end of the write time; store has no reset
    always @(posedge i_clk) begin
        if (write_done) begin
            mem[write_addr] <= write_byte;
        end
    end

    // Register read mux, reserved bits zero
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_io_rdata <= 8'h00;
        end else if (i_io_rd) begin
            case (i_io_addr)
                `NVBAP_IDX_CTRL:    o_io_rdata <= {5'h00, master_write_arm, write_strobe, 1'h0};
                `NVBAP_IDX_DATA:    o_io_rdata <= nv_byte_data;
                `NVBAP_IDX_ADDR_LO: o_io_rdata <= nv_byte_addr[7:0];
                `NVBAP_IDX_ADDR_HI: o_io_rdata <= {7'h00, nv_byte_addr[8]};
                default:            o_io_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// ==== rtl/nvbap_stall_timer.v ====
// Down-counter that holds a stall or arm window
`timescale 1ns/1ps
module nvbap_stall_timer #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input  wire             i_clk,
    input  wire             i_nrst,
    // Load
    input  wire             i_load,
    input  wire [WIDTH-1:0] i_count,
    // Status
    output wire             o_busy
);
    reg [WIDTH-1:0] count;

    // Reload wins over the running count
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            count <= {WIDTH{1'h0}};
        end else if (i_load) begin
            count <= i_count;
        end else if (count != {WIDTH{1'h0}}) begin
            count <= count - {{(WIDTH-1){1'h0}}, 1'h1};
        end
    end

    // Busy for exactly the loaded number of cycles
    assign o_busy = (count != {WIDTH{1'h0}});
endmodule

// ==== testbench/byte_eeprom_access_port_test.sv ====
// Self-checking bench for the byte access port
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module byte_eeprom_access_port_test;
    reg        i_clk = 1'h0;
    reg        i_nrst = 1'h0;
    reg        i_osc_clk = 1'h0;
    wire [1:0] io_addr;
    wire       io_wr;
    wire       io_rd;
    wire [7:0] io_wdata;
    wire [7:0] io_rdata;
    wire       cpu_stall;
    int        fail_count = 0;
    int        samples_checked = 0;
    reg  [7:0] v;
    nvbap_cpu nvbap_cpu_i (.i_clk(i_clk), .i_rdata(io_rdata), .i_stall(cpu_stall),
        .o_addr(io_addr), .o_wr(io_wr), .o_rd(io_rd), .o_wdata(io_wdata));
    // Short write time keeps the run brief
    nvbap_port #(.WRITE_TICKS(8)) nvbap_port_i (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_io_addr(io_addr), .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wdata(io_wdata),
        .o_io_rdata(io_rdata), .o_cpu_stall(cpu_stall), .i_osc_clk(i_osc_clk));
    initial forever #20 i_clk = ~i_clk;
    // Oscillator period unrelated to the CPU clock
    initial forever #53 i_osc_clk = ~i_osc_clk;
    task complete_run;
        begin
            $display("checks %0d failures %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Poll until the write strobe drops, bounded
    task wait_idle;
        int n;
        begin
            n = 0;
            do begin nvbap_cpu_i.rd(2'h0, v); n++; end while (v[1] && n < 40);
            `CHK(v[1], 1'h0)
        end
    endtask
    // Reserved high bits are written as ones on purpose
    task put(input [8:0] a, input [7:0] d);
        begin
            nvbap_cpu_i.wr(2'h3, {7'h7F, a[8]});
            nvbap_cpu_i.wr(2'h2, a[7:0]);
            nvbap_cpu_i.wr(2'h1, d);
            nvbap_cpu_i.wr(2'h0, 8'h04);
            nvbap_cpu_i.wr(2'h0, 8'h02);
            nvbap_cpu_i.rd(2'h0, v);
            `CHK(v[1], 1'h1)
        end
    endtask
    task get(input [8:0] a);
        begin
            nvbap_cpu_i.wr(2'h3, {7'h00, a[8]});
            nvbap_cpu_i.wr(2'h2, a[7:0]);
            nvbap_cpu_i.wr(2'h0, 8'h01);
            nvbap_cpu_i.rd(2'h1, v);
        end
    endtask
    task t_store;
        begin
            put(9'h000, 8'hA5);
            wait_idle;
            put(9'h1FF, 8'h5A);
            wait_idle;
            nvbap_cpu_i.rd(2'h3, v);
            `CHK(v, 8'h01)
            get(9'h000);
            `CHK(v, 8'hA5)
            get(9'h1FF);
            `CHK(v, 8'h5A)
            $display("store test done");
        end
    endtask
    task t_arm;
        begin
            nvbap_cpu_i.wr(2'h0, 8'h04);
            nvbap_cpu_i.rd(2'h0, v);
            `CHK(v[2], 1'h1)
            repeat (6) @(posedge i_clk);
            nvbap_cpu_i.rd(2'h0, v);
            `CHK(v[2], 1'h0)
            nvbap_cpu_i.wr(2'h0, 8'h02);
            nvbap_cpu_i.rd(2'h0, v);
            `CHK(v[1], 1'h0)
            $display("arm test done");
        end
    endtask
    // Address change and read strobe land inside the write time
    task t_busy;
        begin
            put(9'h005, 8'h77);
            nvbap_cpu_i.wr(2'h2, 8'h06);
            nvbap_cpu_i.wr(2'h0, 8'h01);
            nvbap_cpu_i.rd(2'h1, v);
            `CHK(v, 8'h77)
            wait_idle;
            nvbap_cpu_i.rd(2'h2, v);
            `CHK(v, 8'h05)
            $display("busy test done");
        end
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'h1;
        nvbap_cpu_i.rd(2'h1, v);
        `CHK(v, 8'h00)
        t_store;
        t_arm;
        t_busy;
        complete_run;
    end
    initial begin
        #100000;
        fail_count++;
        complete_run;
    end
endmodule

// ==== testbench/nvbap_checker.sv ====
// Concurrent checks on the byte access port pins
`timescale 1ns/1ps
module nvbap_checker #(
    parameter WRITE_TICKS = 8
) (
    input wire       i_clk,
    input wire       i_nrst,
    input wire [1:0] i_io_addr,
    input wire       i_io_wr,
    input wire       i_io_rd,
    input wire [7:0] i_io_wdata,
    input wire [7:0] o_io_rdata,
    input wire       o_cpu_stall,
    input wire       i_osc_clk
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Control writes are the only cause of a stall
    wire ctl_wr = i_io_wr && (i_io_addr == 2'h0);
    // A refused strobe shows no stall at all, so both shapes allow that
    sequence stall4_s; o_cpu_stall [*4] ##1 !o_cpu_stall; endsequence
    sequence stall2_s; o_cpu_stall [*2] ##1 !o_cpu_stall; endsequence
    rd_stall_a: assert property (ctl_wr && i_io_wdata == 8'h01 |=> stall4_s or !o_cpu_stall)
        else $error("read stall length wrong");
    wr_stall_a: assert property (ctl_wr && i_io_wdata == 8'h02 |=> stall2_s or !o_cpu_stall)
        else $error("write stall length wrong");
    stall_cause_a: assert property (!o_cpu_stall && !ctl_wr |=> !o_cpu_stall)
        else $error("stall without a strobe");
    rdata_hold_a: assert property (!i_io_rd |=> $stable(o_io_rdata))
        else $error("read data moved without a read");
    hi_zero_a: assert property (i_io_rd && i_io_addr == 2'h3 |=> o_io_rdata[7:1] == 7'h00)
        else $error("reserved address bits not zero");
    ctrl_zero_a: assert property (i_io_rd && i_io_addr == 2'h0 |=> o_io_rdata[0] == 1'h0)
        else $error("read strobe bit still set");
    arm_seen_a: assert property (ctl_wr && i_io_wdata == 8'h04 ##[1:2] i_io_rd && i_io_addr == 2'h0
        |=> o_io_rdata[2])
        else $error("arm bit not visible");
    reset_clear_a: assert property ($rose(i_nrst) |-> !o_cpu_stall && o_io_rdata == 8'h00)
        else $error("outputs not clear after reset");
endmodule
bind nvbap_port nvbap_checker #(.WRITE_TICKS(WRITE_TICKS)) nvbap_checker_i (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .o_cpu_stall(o_cpu_stall),
    .i_osc_clk(i_osc_clk));

// ==== testbench/nvbap_cpu.sv ====
// Processor core model issuing single-cycle I/O register accesses
`timescale 1ns/1ps
module nvbap_cpu (
    // Clock and port answers
    input  wire       i_clk,
    input  wire [7:0] i_rdata,
    input  wire       i_stall,
    // I/O register bus
    output reg  [1:0] o_addr  = 2'h0,
    output reg        o_wr    = 1'h0,
    output reg        o_rd    = 1'h0,
    output reg  [7:0] o_wdata = 8'h00
);
    // A halted core issues nothing, so wait out any stall first
    task issue(input [1:0] a, input [7:0] d, input w);
        begin
            @(posedge i_clk);
            while (i_stall) @(posedge i_clk);
            o_addr <= a;
            o_wdata <= d;
            o_wr <= w;
            o_rd <= !w;
            @(posedge i_clk);
            o_wr <= 1'h0;
            o_rd <= 1'h0;
        end
    endtask
    task wr(input [1:0] a, input [7:0] d);
        issue(a, d, 1'h1);
    endtask
    // Data is registered, so it is taken one edge after the strobe
    task rd(input [1:0] a, output [7:0] d);
        begin
            issue(a, 8'h00, 1'h0);
            @(posedge i_clk);
            d = i_rdata;
        end
    endtask
endmodule
